// ===== rtl/codec_port_cfg.svh
// codec_port_cfg.svh: offsets, field positions, reset values and counts
// assumes: included by the codec serial port sources only
`ifndef CODEC_PORT_CFG_SVH
`define CODEC_PORT_CFG_SVH

// register byte offsets
`define OFS_CTRL1     8'h00
`define OFS_CTRL2     8'h04
`define OFS_CTRL3     8'h08
`define OFS_STATUS    8'h0C
`define OFS_RXBUF     8'h10
`define OFS_TXBUF     8'h20
`define OFS_SPAN      8'h10

// control_word_one field positions
`define B_ENABLE      0
`define B_CLK_DIR     1
`define B_IDLE_MODE   2
`define B_FS_DIR      3
`define B_EDGE_SEL    4
`define B_MODE_LO     5
`define B_MODE_HI     6

// reset values
`define CTRL1_RST     7'h00
`define CTRL2_RST     8'h00
`define DIV_RST       12'h000

// framing counts
`define AC_LAST_POS   8'hFF
`define AC_FS_LEAD    8'h0F
`define AC_TAG_END    8'h10
`define SLOT16_LAST   5'h0F
`define SLOT20_LAST   5'h13

`endif

// ===== rtl/codec_port_pkg.sv
// codec_port_pkg: types shared by the codec serial port
// assumes: nothing beyond the compile order
package codec_port_pkg;

    typedef enum logic [1:0]
    {
        fs_multi = 2'b00,
        fs_i2s   = 2'b01,
        fs_ac16  = 2'b10,
        fs_ac20  = 2'b11
    } fs_mode_t;

    typedef enum logic [1:0]
    {
        st_idle = 2'b01,
        st_run  = 2'b10
    } frame_state_t;

endpackage : codec_port_pkg

// ===== rtl/bit_clock_gen.sv
// bit_clock_gen: divider producing the serial bit clock level
// assumes: run is synchronous to ref_clk; divider is static while running
`timescale 1ns/1ns
module bit_clock_gen
(
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic        run,
    input  wire logic [11:0] divider,
    output logic             clk_level
);

    logic [11:0] cnt_reg;

    // level toggles every divider+1 cycles: period 2*(divider+1)
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_reg   <= 12'h000;
            clk_level <= 1'b0;
        end
        else if (!run)
        begin
            cnt_reg   <= 12'h000;
            clk_level <= 1'b0;
        end
        else if (cnt_reg == divider)
        begin
            cnt_reg   <= 12'h000;
            clk_level <= ~clk_level;
        end
        else
        begin
            cnt_reg <= cnt_reg + 12'h001;
        end
    end

endmodule : bit_clock_gen

// ===== rtl/converter_serial_port.sv
// converter_serial_port: framed codec serial port with APB registers
// assumes: pins are asynchronous to ref_clk; bit clock well below ref_clk/4
//
// Behaviour
// RQ1: direction bit chooses driven or received bit clock
// RQ2: data out driven only in words, else Z/0
// RQ3: enabled port owns pins; data in is input
// RQ4: frame sync direction bit: master or slave
// RQ5: left justified words, receive low bits zeroed; 20-bit AC-Link slots are received as their last 16 bits
// RQ6: one 16-bit shift register, MSB first
// RQ7: one 2-bit pointer addresses both shadow buffers
// RQ8: clearing enable resets counters, stops frame sync; bit clock generator keeps running
// RQ9: bit clock pin usable with generator alone
// RQ10: word length field sets bit counter period
// RQ11: frame counter advances on word wrap
// RQ12: AC-Link ignores length fields, 256-bit frame
// RQ13: mode field picks multichannel, I2S, AC-Link
// RQ14: master issues sync when frame counter wraps
// RQ15: multichannel master sync one bit wide
// RQ16: AC-Link master sync 16 high, 240 low
// RQ17: I2S master sync is 50% square wave
// RQ18: multichannel slave starts one bit after sync
// RQ19: I2S slave starts one bit after edge
// RQ20: AC-Link slave starts one bit after sync
// RQ21: slave ignores syncs until frame completes
// RQ22: serial side works on shadow buffers
// RQ23: divider field sets bit clock, zero stops
// RQ24: edge select bit picks sampling edge
// RQ25: sample on chosen edge, drive on other
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "codec_port_cfg.svh"
module converter_serial_port
    import codec_port_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        bit_clk_in,
    output logic             bit_clk_out,
    output logic             bit_clk_oe,
    input  wire logic        frame_sync_in,
    output logic             frame_sync_out,
    output logic             frame_sync_oe,
    input  wire logic        serial_data_in,
    output logic             serial_data_out,
    output logic             serial_data_oe
);

    ////////////////////////////////////////////////////////////////////////
    // functions

    function automatic logic [4:0] reg_index(input logic [7:0] a);
        reg_index = {1'b0, a[5:2]};
        if (a[7:6] != 2'b00 || a[1:0] != 2'b00)
        begin
            reg_index = 5'h1F;
        end
    endfunction : reg_index

    function automatic logic [15:0] left_just(input logic [15:0] w,
                                              input logic [4:0]  last);
        logic [3:0] sh;
        sh = 4'hF - last[3:0];
        if (last > 5'h0F)
        begin
            sh = 4'h0;
        end
        left_just = w << sh;
    endfunction : left_just

    ////////////////////////////////////////////////////////////////////////
    // declarations

    logic [6:0]   ctrl1_reg;
    logic [7:0]   ctrl2_reg;
    logic [11:0]  div_reg;
    logic [15:0]  tx_buf [0:3];
    logic [15:0]  rx_buf [0:3];
    logic [15:0]  shadow [0:7];
    logic [2:0]   pin_s1_reg;
    logic [2:0]   pin_s2_reg;
    logic         sck_prev_reg;
    logic         fs_last_reg;
    logic         start_pend_reg;
    frame_state_t state_reg;
    frame_state_t state_next;
    logic [4:0]   bit_reg;
    logic [4:0]   bit_next;
    logic [3:0]   frm_reg;
    logic [3:0]   frm_next;
    logic [7:0]   pos_reg;
    logic [7:0]   pos_next;
    logic [1:0]   ptr_reg;
    logic [1:0]   ptr_next;
    logic [15:0]  sr_reg;
    logic         gen_clk;
    logic         enable;
    logic         master;
    logic         gen_run;
    logic         sck_now;
    logic         samp;
    logic         drv;
    logic [4:0]   wlast;
    logic         word_end;
    logic         frame_end;
    logic         go;
    logic         accept;
    logic         hit;
    logic         load_word;
    logic         store_word;
    logic         fs_next;
    logic [3:0]   half;
    logic [3:0]   nxt_word;
    logic [15:0]  load_data;
    logic [4:0]   idx;
    fs_mode_t     mode;

    assign enable  = ctrl1_reg[`B_ENABLE];
    assign master  = ~ctrl1_reg[`B_FS_DIR];                        // RQ4
    assign mode    = fs_mode_t'(ctrl1_reg[`B_MODE_HI:`B_MODE_LO]); // RQ13
    assign gen_run = ~ctrl1_reg[`B_CLK_DIR] & (div_reg != `DIV_RST);
    assign idx     = reg_index(paddr);

    ////////////////////////////////////////////////////////////////////////
    // bit clock source and edges

    bit_clock_gen u_gen
    (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .run       (gen_run),                                      // RQ23
        .divider   (div_reg),
        .clk_level (gen_clk)
    );

    // pins: {data, sync, clock}; first stage feeds only the second
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pin_s1_reg <= 3'h0;
            pin_s2_reg <= 3'h0;
        end
        else
        begin
            pin_s1_reg <= {serial_data_in, frame_sync_in, bit_clk_in};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    assign sck_now = ctrl1_reg[`B_CLK_DIR] ? pin_s2_reg[0] : gen_clk; // RQ1

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sck_prev_reg <= 1'b0;
        end
        else
        begin
            sck_prev_reg <= sck_now;
        end
    end

    // sampling on falling edge unless edge select set
    assign samp = enable & (ctrl1_reg[`B_EDGE_SEL] ?              // RQ24
                  (sck_now & ~sck_prev_reg) : (~sck_now & sck_prev_reg));
    assign drv  = enable & (ctrl1_reg[`B_EDGE_SEL] ?              // RQ25
                  (~sck_now & sck_prev_reg) : (sck_now & ~sck_prev_reg));

    ////////////////////////////////////////////////////////////////////////
    // framing counters

    always_comb
    begin
        unique case (mode)
            fs_multi, fs_i2s: wlast = {1'b0, ctrl2_reg[3:0]};     // RQ10
            fs_ac16:          wlast = `SLOT16_LAST;               // RQ12
            fs_ac20:          wlast = (pos_reg < `AC_TAG_END) ?
                                      `SLOT16_LAST : `SLOT20_LAST;
        endcase
    end

    assign word_end  = (bit_reg == wlast);
    assign frame_end = word_end & (mode[1] ? (pos_reg == `AC_LAST_POS)
                                   : (frm_reg == ctrl2_reg[7:4])); // RQ11
    assign go        = master | start_pend_reg;

    always_comb
    begin
        state_next = state_reg;
        bit_next   = bit_reg;
        frm_next   = frm_reg;
        pos_next   = pos_reg;
        ptr_next   = ptr_reg;
        load_word  = 1'b0;
        store_word = 1'b0;
        if (drv)
        begin
            unique case (state_reg)
                st_idle:
                begin
                    if (go)
                    begin
                        state_next = st_run;
                        bit_next   = 5'h00;
                        frm_next   = 4'h0;
                        pos_next   = 8'h00;
                        load_word  = 1'b1;
                    end
                end
                st_run:
                begin
                    pos_next = pos_reg + 8'h01;
                    if (word_end)
                    begin
                        store_word = 1'b1;
                        ptr_next   = ptr_reg + 2'h1;              // RQ7
                        bit_next   = 5'h00;
                        if (frame_end)
                        begin
                            frm_next = 4'h0;                      // RQ14
                            pos_next = 8'h00;
                            if (go)
                            begin
                                load_word = 1'b1;
                            end
                            else
                            begin
                                state_next = st_idle;
                            end
                        end
                        else
                        begin
                            frm_next  = frm_reg + 4'h1;           // RQ11
                            load_word = 1'b1;
                        end
                    end
                    else
                    begin
                        bit_next = bit_reg + 5'h01;               // RQ10
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= st_idle;
            bit_reg   <= 5'h00;
            frm_reg   <= 4'h0;
            pos_reg   <= 8'h00;
            ptr_reg   <= 2'h0;
        end
        else if (!enable)
        begin
            state_reg <= st_idle;                                 // RQ8
            bit_reg   <= 5'h00;
            frm_reg   <= 4'h0;
            pos_reg   <= 8'h00;
            ptr_reg   <= 2'h0;
        end
        else
        begin
            state_reg <= state_next;
            bit_reg   <= bit_next;
            frm_reg   <= frm_next;
            pos_reg   <= pos_next;
            ptr_reg   <= ptr_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // slave sync detection

    assign accept = (state_reg == st_idle) | frame_end;           // RQ21
    assign hit    = (mode == fs_i2s) ? (pin_s2_reg[1] != fs_last_reg) // RQ19
                                     : pin_s2_reg[1];             // RQ18 RQ20

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            fs_last_reg    <= 1'b0;
            start_pend_reg <= 1'b0;
        end
        else if (!enable || master)
        begin
            fs_last_reg    <= 1'b0;
            start_pend_reg <= 1'b0;
        end
        else if (samp)
        begin
            fs_last_reg <= pin_s2_reg[1];
            if (accept && hit)
            begin
                start_pend_reg <= 1'b1;
            end
        end
        else if (drv)
        begin
            start_pend_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // master frame sync; leads the first bit of its word by one bit

    assign half     = 4'(({1'b0, ctrl2_reg[7:4]} + 5'h01) >> 1);
    assign nxt_word = (frm_next == ctrl2_reg[7:4]) ? 4'h0 : frm_next + 4'h1;

    always_comb
    begin
        unique case (mode)
            fs_multi: fs_next = (bit_next == wlast) &             // RQ15
                                (frm_next == ctrl2_reg[7:4]);
            fs_i2s:   fs_next = (bit_next == wlast) ?             // RQ17
                                (nxt_word >= half) : (frm_next >= half);
            default:  fs_next = (pos_next == `AC_LAST_POS) |      // RQ16
                                (pos_next < `AC_FS_LEAD);
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            frame_sync_out <= 1'b0;
            frame_sync_oe  <= 1'b0;
            bit_clk_oe     <= 1'b0;
            bit_clk_out    <= 1'b0;
        end
        else
        begin
            frame_sync_oe <= enable & master;                     // RQ3 RQ4
            bit_clk_oe    <= ~ctrl1_reg[`B_CLK_DIR] &             // RQ9
                             (enable | gen_run);
            bit_clk_out   <= gen_clk;
            if (!enable || !master)
            begin
                frame_sync_out <= 1'b0;
            end
            else if (drv)
            begin
                frame_sync_out <= fs_next;                        // RQ14
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shift register, data pin and shadow buffers

    assign load_data = (store_word && ptr_reg == 2'h3) ? tx_buf[0]
                       : shadow[{1'b1, ptr_next}];                // RQ7

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sr_reg          <= 16'h0000;
            serial_data_out <= 1'b0;
            serial_data_oe  <= 1'b0;
        end
        else if (!enable)
        begin
            sr_reg          <= 16'h0000;
            serial_data_out <= 1'b0;
            serial_data_oe  <= 1'b0;
        end
        else if (samp && state_reg == st_run)
        begin
            sr_reg <= {sr_reg[14:0], pin_s2_reg[2]};              // RQ6
        end
        else if (drv)
        begin
            serial_data_oe <= load_word | ~ctrl1_reg[`B_IDLE_MODE] | // RQ2
                              (state_reg == st_run & ~word_end);
            if (load_word)
            begin
                sr_reg          <= load_data;
                serial_data_out <= load_data[15];                 // RQ6
            end
            else if (state_reg == st_run && !word_end && bit_reg < 5'h0F)
            begin
                serial_data_out <= sr_reg[15];
            end
            else
            begin
                serial_data_out <= 1'b0;                          // RQ5
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < 8; i++)
            begin
                shadow[i] <= 16'h0000;
            end
            for (int i = 0; i < 4; i++)
            begin
                rx_buf[i] <= 16'h0000;
            end
        end
        else if (!enable)
        begin
            for (int i = 0; i < 4; i++)
            begin
                shadow[4 + i] <= tx_buf[i];
            end
        end
        else if (store_word)
        begin
            shadow[{1'b0, ptr_reg}] <= left_just(sr_reg, wlast);  // RQ5 RQ22
            if (ptr_reg == 2'h3)
            begin
                for (int i = 0; i < 3; i++)
                begin
                    rx_buf[i]     <= shadow[i];                   // RQ22
                    shadow[4 + i] <= tx_buf[i];
                end
                rx_buf[3] <= left_just(sr_reg, wlast);
                shadow[7] <= tx_buf[3];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, writes land with pready

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            prdata    <= 32'h0000_0000;
            ctrl1_reg <= `CTRL1_RST;
            ctrl2_reg <= `CTRL2_RST;
            div_reg   <= `DIV_RST;
            for (int i = 0; i < 4; i++)
            begin
                tx_buf[i] <= 16'h0000;
            end
        end
        else if (psel && penable && !pready)
        begin
            pready  <= 1'b1;
            pslverr <= (idx > 5'h0B);
            prdata  <= 32'h0000_0000;
            unique case (idx)
                5'h00: prdata <= {25'h0, ctrl1_reg};
                5'h01: prdata <= {24'h0, ctrl2_reg};
                5'h02: prdata <= {20'h0, div_reg};
                5'h03: prdata <= {16'h0, ptr_reg, 1'b0, state_reg[1],
                                  frm_reg, 3'h0, bit_reg};
                5'h04, 5'h05, 5'h06, 5'h07:
                       prdata <= {16'h0, rx_buf[idx[1:0]]};
                5'h08, 5'h09, 5'h0A, 5'h0B:
                       prdata <= {16'h0, tx_buf[idx[1:0]]};
                default: prdata <= 32'h0000_0000;
            endcase
        end
        else if (psel && penable)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            if (pwrite)
            begin
                unique case (idx)
                    5'h00: ctrl1_reg <= pwdata[6:0];
                    5'h01: ctrl2_reg <= pwdata[7:0];
                    5'h02: div_reg   <= pwdata[11:0];
                    5'h08, 5'h09, 5'h0A, 5'h0B:
                           tx_buf[idx[1:0]] <= pwdata[15:0];
                    default: ;
                endcase
            end
        end
        else
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule : converter_serial_port

// ===== bench/converter_serial_port_properties.sv
// converter_serial_port_properties: port checker for the codec serial port
// assumes: bound to converter_serial_port; divider static while driving
`timescale 1ns/1ns
`include "codec_port_cfg.svh"
module converter_serial_port_properties
(
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        bit_clk_out,
    input wire logic        bit_clk_oe,
    input wire logic        frame_sync_oe,
    input wire logic        serial_data_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    sequence access_wait;
        psel && penable && !pready;
    endsequence
    sequence ctrl1_write;
        psel && penable && pready && pwrite && paddr == `OFS_CTRL1;
    endsequence

    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    ready_after_access_a: assert property (access_wait |=> pready)
        else $error("no answer one cycle after access");
    error_zero_data_a: assert property
        (pslverr |-> pready && prdata == 32'h00000000)
        else $error("error response without ready or with data");
    master_sync_drive_a: assert property
        (ctrl1_write ##0 (pwdata[0] && !pwdata[3]) |-> ##[1:3] frame_sync_oe)
        else $error("master frame sync not driven");
    slave_sync_input_a: assert property
        (ctrl1_write ##0 pwdata[3] |-> ##3 !frame_sync_oe)
        else $error("slave still drives frame sync");
    disable_release_a: assert property
        (ctrl1_write ##0 !pwdata[0] |-> ##4 !(frame_sync_oe || serial_data_oe))
        else $error("pins still driven after disable");
    clock_input_a: assert property
        (ctrl1_write ##0 pwdata[1] |-> ##4 !bit_clk_oe)
        else $error("bit clock driven while set as input");
    bit_clock_hold_a: assert property
        (bit_clk_oe && $changed(bit_clk_out) |=> $stable(bit_clk_out))
        else $error("bit clock half period shorter than two cycles");
endmodule : converter_serial_port_properties

bind converter_serial_port converter_serial_port_properties
    i_converter_serial_port_properties
(
    .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bit_clk_out(bit_clk_out),
    .bit_clk_oe(bit_clk_oe), .frame_sync_oe(frame_sync_oe),
    .serial_data_oe(serial_data_oe)
);

// ===== bench/codec_partner.sv
// codec_partner: external codec as bit clock and frame sync master
// assumes: device samples on the falling bit clock edge, 64-bit frames
`timescale 1ns/1ns
module codec_partner
(
    input  wire logic        run,
    input  wire logic [63:0] frame_bits,
    output logic             bit_clk,
    output logic             frame_sync,
    output logic             data
);
    int pos = 63;
    initial
    begin
        bit_clk = 1'b0;
        frame_sync = 1'b0;
        data = 1'b0;
        forever
        begin
            wait (run);
            pos = 63;
            // clock runs only inside frames, a frame is always finished
            while (run || pos != 0)
            begin
                #160 bit_clk = 1'b1;
                frame_sync = (pos == 63);
                data = frame_bits[63 - pos];
                #160 bit_clk = 1'b0;
                pos = (pos + 1) % 64;
            end
            frame_sync = 1'b0;
            data = ~data;
        end
    end
endmodule : codec_partner

// ===== bench/test_converter_serial_port.sv
// test_converter_serial_port: self-checking bench for the codec port
// assumes: checker and partner model compiled before this file
`timescale 1ns/1ns
module test_converter_serial_port;
    logic        ref_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, p_run = 1'b0, err;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000, rd, r, seed = 32'h00000007;
    logic [31:0] prdata;
    logic        pready, pslverr, bck_o, bck_oe, fs_o, fs_oe, sd_o, sd_oe;
    logic        p_clk, p_fs, p_sd;
    logic [63:0] p_bits = 64'h0;
    logic [15:0] tx [4];
    logic [3:0]  f;
    int          error_cnt = 0, comparisons = 0, n;

    always #10 ref_clk = ~ref_clk;
    // master: data looped back; slave: codec drives data in
    wire bck = bck_oe ? bck_o : p_clk;
    wire fsi = fs_oe ? fs_o : p_fs;
    wire sdi = fs_oe ? (sd_oe ? sd_o : ~sd_o) : p_sd;

    converter_serial_port i_converter_serial_port
    (
        .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bit_clk_in(bck),
        .bit_clk_out(bck_o), .bit_clk_oe(bck_oe), .frame_sync_in(fsi),
        .frame_sync_out(fs_o), .frame_sync_oe(fs_oe),
        .serial_data_in(sdi), .serial_data_out(sd_o),
        .serial_data_oe(sd_oe)
    );
    codec_partner i_codec_partner
    (
        .run(p_run), .frame_bits(p_bits), .bit_clk(p_clk),
        .frame_sync(p_fs), .data(p_sd)
    );

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    // left justified word of length f+1
    function automatic logic [31:0] lj(input logic [15:0] v,
                                       input logic [3:0] w);
        return {16'h0000, v & ~(16'hFFFF >> ({1'b0, w} + 5'h01))};
    endfunction : lj

    task automatic chk(input string what, input logic [31:0] got, exp);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do @(posedge ref_clk); while (pready !== 1'b1 && n++ < 50);
        if (n >= 50)
            error_cnt++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic sync_shape(input logic [31:0] c1, c2, input int hi, lo);
        int h = 0, l = 0;
        apb(1'b1, 8'h00, 32'h00000000);
        apb(1'b1, 8'h04, c2);
        apb(1'b1, 8'h00, c1);
        for (n = 0; fs_o !== 1'b1 && n < 9000; n++)
            @(posedge ref_clk);
        for (n = 0; fs_o === 1'b1 && n < 9000; n++)
            @(posedge ref_clk);
        for (n = 0; fs_o !== 1'b1 && n < 9000; n++)
            @(posedge ref_clk);
        for (; fs_o === 1'b1 && h < 9000; h++)
            @(posedge ref_clk);
        for (; fs_o !== 1'b1 && l < 9000; l++)
            @(posedge ref_clk);
        chk("sync high cycles", h, hi * 16);
        chk("sync low cycles", l, lo * 16);
    endtask : sync_shape

    task automatic summarize();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (6) @(posedge ref_clk);
        rstn <= 1'b1;
        for (int a = 0; a < 12; a += 4)
        begin
            apb(1'b0, 8'(a), 32'h0);
            chk("reset value", rd, 32'h00000000);
        end
        apb(1'b0, 8'h30, 32'h0);
        chk("unmapped error", {31'h0, err}, 32'h00000001);
        apb(1'b1, 8'h10, 32'hFFFF);
        apb(1'b0, 8'h10, 32'h0);
        chk("rx buffer read only", rd, 32'h00000000);
        repeat (3)
        begin
            r = xs();
            apb(1'b1, 8'h08, r);
            apb(1'b0, 8'h08, 32'h0);
            chk("divider", rd, r & 32'h00000FFF);
        end
        apb(1'b1, 8'h08, 32'h7);
        sync_shape(32'h01, 32'h3F, 1, 63);
        sync_shape(32'h21, 32'h37, 16, 16);
        sync_shape(32'h41, 32'h00, 16, 240);
        sync_shape(32'h61, 32'hFF, 16, 240);
        for (int k = 0; k < 2; k++)
        begin
            apb(1'b1, 8'h00, 32'h0);
            r = xs();
            f = k ? r[3:0] : 4'hF;
            for (int i = 0; i < 4; i++)
            begin
                r = xs();
                tx[i] = r[15:0];
                apb(1'b1, 8'(8'h20 + 4 * i), {16'h0, tx[i]});
            end
            apb(1'b1, 8'h04, {24'h0, 4'h3, f});
            apb(1'b1, 8'h00, k ? 32'h15 : 32'h01);
            repeat (256 * ({28'h0, f} + 1)) @(posedge ref_clk);
            for (int i = 0; i < 4; i++)
            begin
                apb(1'b0, 8'(8'h10 + 4 * i), 32'h0);
                chk("loopback word", rd, lj(tx[i], f));
            end
        end
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h04, 32'h3F);
        p_bits = {xs(), xs()};
        apb(1'b1, 8'h00, 32'h0B);
        p_run <= 1'b1;
        repeat (4 * 64 * 16) @(posedge ref_clk);
        p_run <= 1'b0;
        repeat (64 * 16 + 40) @(posedge ref_clk);
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, 8'(8'h10 + 4 * i), 32'h0);
            chk("slave word", rd, {16'h0, p_bits[63 - 16 * i -: 16]});
        end
        summarize();
    end

    initial
    begin
        #2000000;
        error_cnt++;
        summarize();
    end
endmodule : test_converter_serial_port
